// [common/timer_pkg.sv]
package timer_pkg;

  // ----------------------------------------------------------------
  // Port decode on the two port-select lines
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_CNT0 = 2'h0;
  localparam logic [1:0] PORT_CNT1 = 2'h1;
  localparam logic [1:0] PORT_CNT2 = 2'h2;
  localparam logic [1:0] PORT_CTRL = 2'h3;

  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int CW_SEL_LSB = 6;
  localparam int CW_ACC_LSB = 4;
  localparam int CW_MODE_LSB = 1;
  localparam int CW_BCD_BIT = 0;
  localparam logic [1:0] SEL_ILLEGAL = 2'h3;

  // Byte-access field codes
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LSB = 2'h1;
  localparam logic [1:0] ACC_MSB = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Counting constants
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] HALF_MAX_BIN = 16'h8000;
  localparam logic [15:0] HALF_MAX_BCD = 16'h5000;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_FIVE = 4'h5;

  typedef enum logic [2:0] {
    MODE_TC = 3'h0,
    MODE_ONESHOT = 3'h1,
    MODE_RATE = 3'h2,
    MODE_SQUARE = 3'h3,
    MODE_SWSTROBE = 3'h4,
    MODE_HWSTROBE = 3'h5
  } mode_e;

endpackage

// [logic/interval_timer.sv]
module interval_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_select_0,
  input wire logic port_select_1,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [2:0] count_clk,
  input wire logic [2:0] gate,
  output logic [2:0] count_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_s1, cs_s2, rd_s1, rd_s2, rd_p, wr_s1, wr_s2, wr_p, ps0_s1, ps0_s2, ps1_s1, ps1_s2;
    logic [7:0] din_s1, din_s2;
    logic [2:0] cclk_s1, cclk_s2, cclk_p, gate_s1, gate_s2, gate_p, trig, running, pend, have, out, wptr, rptr;
    logic [2:0] latched, bcd;
    logic [2:0][1:0] acc;
    timer_pkg::mode_e [2:0] mode;
    logic [2:0][15:0] init, count, period, latch;
    logic [7:0] dout;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [2:0] tick;
  logic [2:0] gate_rise;
  logic [1:0] port;
  logic wr_done;
  logic rd_go;
  logic cw_ev;

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] dec16(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - timer_pkg::COUNT_ONE;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (borrow) begin
          if (r[4*k +: 4] == 4'h0) begin
            r[4*k +: 4] = timer_pkg::BCD_NINE;
          end else begin
            r[4*k +: 4] = r[4*k +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // Low-phase length floor(N/2); a zero load stands for the full range
  function automatic logic [15:0] half16(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic carry;
    r = v >> 1;
    carry = 1'b0;
    if (v == timer_pkg::COUNT_ZERO) begin
      r = bcd ? timer_pkg::HALF_MAX_BCD : timer_pkg::HALF_MAX_BIN;
    end else if (bcd) begin
      for (int k = 3; k >= 0; k--) begin
        r[4*k +: 4] = (v[4*k +: 4] >> 1) + (carry ? timer_pkg::BCD_FIVE : 4'h0);
        carry = v[4*k];
      end
    end
    return r;
  endfunction

  assign tick = st_q.cclk_s2 & ~st_q.cclk_p;
  assign gate_rise = st_q.gate_s2 & ~st_q.gate_p;
  assign port = {st_q.ps1_s2, st_q.ps0_s2};
  // Writes act on the strobe's trailing edge, when data has settled
  assign wr_done = st_q.wr_p & ~st_q.wr_s2 & st_q.cs_s2;
  assign rd_go = st_q.rd_s2 & ~st_q.rd_p & st_q.cs_s2;
  assign cw_ev = wr_done && port == timer_pkg::PORT_CTRL;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] nx;
    logic [15:0] src;
    logic [7:0] d;
    logic [1:0] sel;
    nx = 16'h0000;
    src = 16'h0000;
    d = st_q.din_s2;
    sel = d[timer_pkg::CW_SEL_LSB +: 2];
    st_d = st_q;
    // Pins pass two stages; strobes, count clocks and gates add a third stage that also feeds edge detection
    {st_d.cs_s2, st_d.cs_s1} = {st_q.cs_s1, ~cs_n};
    {st_d.rd_p, st_d.rd_s2, st_d.rd_s1} = {st_q.rd_s2, st_q.rd_s1, ~rd_n};
    {st_d.wr_p, st_d.wr_s2, st_d.wr_s1} = {st_q.wr_s2, st_q.wr_s1, ~wr_n};
    {st_d.ps0_s2, st_d.ps0_s1} = {st_q.ps0_s1, port_select_0};
    {st_d.ps1_s2, st_d.ps1_s1} = {st_q.ps1_s1, port_select_1};
    {st_d.din_s2, st_d.din_s1} = {st_q.din_s1, data_in};
    {st_d.cclk_p, st_d.cclk_s2, st_d.cclk_s1} = {st_q.cclk_s2, st_q.cclk_s1, count_clk};
    {st_d.gate_p, st_d.gate_s2, st_d.gate_s1} = {st_q.gate_s2, st_q.gate_s1, gate};

    for (int i = 0; i < 3; i++) begin
      // Gate rise is held until the next count clock; a rise wins over the clear
      st_d.trig[i] = (st_q.trig[i] & ~tick[i]) | gate_rise[i];
      if (tick[i]) begin
        nx = dec16(st_q.count[i], st_q.bcd[i]);
        case (st_q.mode[i])
          timer_pkg::MODE_TC: begin
            if (st_q.pend[i]) begin
              st_d.count[i] = st_q.init[i];
              st_d.running[i] = 1'b1;
              st_d.pend[i] = 1'b0;
              st_d.out[i] = 1'b0;
            end else if (st_q.running[i] && st_q.gate_s2[i]) begin
              st_d.count[i] = nx;
              if (nx == timer_pkg::COUNT_ZERO) begin
                st_d.out[i] = 1'b1;
              end
            end
          end
          timer_pkg::MODE_ONESHOT: begin
            if (st_q.trig[i] && st_q.have[i]) begin
              st_d.count[i] = st_q.init[i];
              st_d.out[i] = 1'b0;
              st_d.running[i] = 1'b1;
            end else if (st_q.running[i]) begin
              st_d.count[i] = nx;
              if (nx == timer_pkg::COUNT_ZERO) begin
                st_d.out[i] = 1'b1;
                st_d.running[i] = 1'b0;
              end
            end
          end
          timer_pkg::MODE_RATE, timer_pkg::MODE_SQUARE: begin
            if (!st_q.gate_s2[i]) begin
              st_d.out[i] = 1'b1;
            end else if (st_q.have[i] && (st_q.trig[i] || !st_q.running[i])) begin
              st_d.count[i] = st_q.init[i];
              st_d.period[i] = st_q.init[i];
              st_d.running[i] = 1'b1;
              st_d.pend[i] = 1'b0;
              st_d.out[i] = 1'b1;
            end else if (st_q.running[i]) begin
              if (st_q.count[i] == timer_pkg::COUNT_ONE) begin
                st_d.count[i] = st_q.init[i];
                st_d.period[i] = st_q.init[i];
                st_d.pend[i] = 1'b0;
                st_d.out[i] = 1'b1;
              end else if (st_q.mode[i] == timer_pkg::MODE_RATE) begin
                st_d.count[i] = nx;
                if (nx == timer_pkg::COUNT_ONE) begin
                  st_d.out[i] = 1'b0;
                end
              end else begin
                st_d.count[i] = nx;
                if (st_q.out[i] && nx == half16(st_q.period[i], st_q.bcd[i])) begin
                  st_d.out[i] = 1'b0;
                  if (st_q.pend[i]) begin
                    // New value shows from this transition onward
                    st_d.count[i] = half16(st_q.init[i], st_q.bcd[i]);
                    st_d.period[i] = st_q.init[i];
                    st_d.pend[i] = 1'b0;
                  end
                end
              end
            end
          end
          timer_pkg::MODE_SWSTROBE: begin
            if (st_q.pend[i]) begin
              st_d.count[i] = st_q.init[i];
              st_d.running[i] = 1'b1;
              st_d.pend[i] = 1'b0;
              st_d.out[i] = 1'b1;
            end else if (!st_q.out[i]) begin
              st_d.out[i] = 1'b1;
            end else if (st_q.running[i] && st_q.gate_s2[i]) begin
              st_d.count[i] = nx;
              if (nx == timer_pkg::COUNT_ZERO) begin
                st_d.out[i] = 1'b0;
                st_d.running[i] = 1'b0;
              end
            end
          end
          timer_pkg::MODE_HWSTROBE: begin
            if (st_q.trig[i] && st_q.have[i]) begin
              st_d.count[i] = st_q.init[i];
              st_d.running[i] = 1'b1;
              st_d.out[i] = 1'b1;
            end else if (!st_q.out[i]) begin
              st_d.out[i] = 1'b1;
            end else if (st_q.running[i]) begin
              st_d.count[i] = nx;
              if (nx == timer_pkg::COUNT_ZERO) begin
                st_d.out[i] = 1'b0;
                st_d.running[i] = 1'b0;
              end
            end
          end
          default: begin
            st_d.out[i] = 1'b1;
          end
        endcase
      end
    end

    // Bus writes; a control word with the illegal select is dropped
    if (cw_ev && sel != timer_pkg::SEL_ILLEGAL) begin
      if (d[timer_pkg::CW_ACC_LSB +: 2] == timer_pkg::ACC_LATCH) begin
        if (!st_q.latched[sel]) begin
          st_d.latch[sel] = st_q.count[sel];
          st_d.latched[sel] = 1'b1;
        end
      end else begin
        st_d.acc[sel] = d[timer_pkg::CW_ACC_LSB +: 2];
        st_d.bcd[sel] = d[timer_pkg::CW_BCD_BIT];
        if (d[timer_pkg::CW_MODE_LSB + 1]) begin
          st_d.mode[sel] = timer_pkg::mode_e'({1'b0, d[timer_pkg::CW_MODE_LSB +: 2]});
        end else begin
          st_d.mode[sel] = timer_pkg::mode_e'(d[timer_pkg::CW_MODE_LSB +: 3]);
        end
        st_d.out[sel] = (d[timer_pkg::CW_MODE_LSB +: 3] != 3'h0);
        {st_d.running[sel], st_d.pend[sel], st_d.have[sel], st_d.wptr[sel], st_d.rptr[sel], st_d.latched[sel]} = 6'h00;
      end
    end else if (wr_done && port != timer_pkg::PORT_CTRL) begin
      case (st_q.acc[port])
        timer_pkg::ACC_LSB, timer_pkg::ACC_MSB: begin
          st_d.init[port] = (st_q.acc[port] == timer_pkg::ACC_LSB) ? {8'h00, d} : {d, 8'h00};
          st_d.pend[port] = 1'b1;
          st_d.have[port] = 1'b1;
        end
        timer_pkg::ACC_BOTH: begin
          if (!st_q.wptr[port]) begin
            st_d.init[port][7:0] = d;
            st_d.wptr[port] = 1'b1;
            if (st_q.mode[port] == timer_pkg::MODE_TC) begin
              st_d.running[port] = 1'b0;
            end
          end else begin
            st_d.init[port][15:8] = d;
            st_d.wptr[port] = 1'b0;
            st_d.pend[port] = 1'b1;
            st_d.have[port] = 1'b1;
          end
        end
        default: begin
          st_d.wptr[port] = 1'b0;
        end
      endcase
    end

    // Bus reads; the control location answers nothing
    if (rd_go && port != timer_pkg::PORT_CTRL) begin
      src = st_q.latched[port] ? st_q.latch[port] : st_q.count[port];
      case (st_q.acc[port])
        timer_pkg::ACC_MSB: begin
          st_d.dout = src[15:8];
          st_d.latched[port] = 1'b0;
        end
        timer_pkg::ACC_BOTH: begin
          st_d.dout = st_q.rptr[port] ? src[15:8] : src[7:0];
          st_d.rptr[port] = ~st_q.rptr[port];
          st_d.latched[port] = st_q.latched[port] & ~st_q.rptr[port];
        end
        default: begin
          st_d.dout = src[7:0];
          st_d.latched[port] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign data_out = st_q.dout;
  assign data_oe = st_q.rd_s2 & st_q.cs_s2 & (port != timer_pkg::PORT_CTRL);
  assign count_out = st_q.out;

  // ----------------------------------------------------------------
  // Checks on counter 0, plus one on reads of the control location
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || !ce);

  sequence s_rate_end;
    st_q.mode[0] == timer_pkg::MODE_RATE && st_q.gate_s2[0] && st_q.running[0] && !st_q.trig[0]
      && tick[0] && st_q.count[0] == timer_pkg::COUNT_ONE;
  endsequence
  sequence s_strobe_low;
    st_q.mode[0] == timer_pkg::MODE_SWSTROBE && !st_q.out[0] && !st_q.pend[0] && tick[0];
  endsequence

  a_mode0_set_low: assert property (cw_ev && st_q.din_s2[7:6] == 2'h0 && st_q.din_s2[5:4] != 2'h0
    && st_q.din_s2[3:1] == 3'h0 |=> !count_out[0]) else $error("mode 0 output not low after set");
  a_mode0_tc_high: assert property (st_q.mode[0] == timer_pkg::MODE_TC && tick[0] && !st_q.pend[0]
    && st_q.running[0] && st_q.gate_s2[0] && st_q.count[0] == timer_pkg::COUNT_ONE && !cw_ev
    |=> count_out[0] && st_q.count[0] == timer_pkg::COUNT_ZERO) else $error("terminal count missed");
  a_gate_low_hold: assert property (st_q.mode[0] == timer_pkg::MODE_TC && tick[0] && !st_q.pend[0]
    && !st_q.gate_s2[0] |=> $stable(st_q.count[0])) else $error("count moved with gate low");
  a_oneshot_fire: assert property (st_q.mode[0] == timer_pkg::MODE_ONESHOT && tick[0] && st_q.trig[0]
    && st_q.have[0] && !wr_done |=> !count_out[0] && st_q.count[0] == $past(st_q.init[0]))
    else $error("one-shot trigger not taken");
  a_rate_gate_high: assert property (st_q.mode[0] == timer_pkg::MODE_RATE && tick[0]
    && !st_q.gate_s2[0] && !cw_ev |=> count_out[0]) else $error("low gate did not force output high");
  a_rate_reload: assert property (s_rate_end and !wr_done |=> count_out[0]
    && st_q.count[0] == $past(st_q.init[0])) else $error("rate period not reloaded");
  a_strobe_one_clk: assert property (s_strobe_low and !cw_ev |=> count_out[0])
    else $error("strobe longer than one count clock");
  a_latch_hold: assert property (st_q.latched[0] && !rd_go && !cw_ev
    |=> st_q.latched[0] && $stable(st_q.latch[0])) else $error("latched count disturbed");
  a_ctrl_no_read: assert property (rd_go && port == timer_pkg::PORT_CTRL
    |=> $stable(data_out) && $stable(st_q.rptr)) else $error("control location answered a read");
  a_lsb_first: assert property (rd_go && port == timer_pkg::PORT_CNT0 && st_q.acc[0] == timer_pkg::ACC_BOTH
    && !st_q.rptr[0] && !st_q.latched[0] |=> data_out == $past(st_q.count[0][7:0]))
    else $error("two-byte read did not start with low byte");

endmodule

// [verif/bus_host.sv]
module bus_host (
  input wire logic ref_clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic port_select_0,
  output logic port_select_1,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    {port_select_1, port_select_0} = 2'h0;
    data_in = 8'h00;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Write strobes and trailing gaps kept at four cycles (read strobe five), the pins pass two sync flops
  task automatic wr(input logic [1:0] port, input logic [7:0] data);
    @(negedge ref_clk);
    {port_select_1, port_select_0} = port;
    data_in = data;
    cs_n = 1'b0;
    @(negedge ref_clk);
    wr_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    wr_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    // Released data shows the inverse so a stale byte cannot pass
    data_in = ~data;
    repeat (4) @(negedge ref_clk);
  endtask

  // Callers always read both bytes of a two-byte counter
  task automatic rd(input logic [1:0] port, output logic [7:0] data, output logic oe);
    @(negedge ref_clk);
    {port_select_1, port_select_0} = port;
    cs_n = 1'b0;
    @(negedge ref_clk);
    rd_n = 1'b0;
    oe = 1'b0;
    repeat (5) begin
      @(posedge ref_clk);
      if (data_oe === 1'b1) oe = 1'b1;
    end
    data = data_out;
    @(negedge ref_clk);
    rd_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask

  // Control word first, then both count bytes low then high
  task automatic load16(input logic [1:0] port, input logic [7:0] cw, input logic [15:0] val);
    wr(timer_pkg::PORT_CTRL, cw);
    wr(port, val[7:0]);
    wr(port, val[15:8]);
  endtask
endmodule

// [verif/programmable_interval_timer_tb.sv]
module programmable_interval_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk, rst, cs_n, rd_n, wr_n, port_select_0, port_select_1, data_oe, oe;
  logic [7:0] data_in, data_out, lo, hi, a, c;
  logic [2:0] count_clk, gate, count_out;
  int error_cnt = 0;
  int checked = 0;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  interval_timer i_dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select_0(port_select_0), .port_select_1(port_select_1), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .count_clk(count_clk), .gate(gate), .count_out(count_out));

  bus_host i_host (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .port_select_0(port_select_0),
    .port_select_1(port_select_1), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Count clock idles low; output sampled well after it settles
  task automatic tick(input int idx, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      count_clk[idx] = 1'b1;
      repeat (4) @(negedge ref_clk);
      count_clk[idx] = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
  endtask

  // Counting lows over whole ticks makes the check phase independent
  task automatic lows(input int idx, input int n, output logic [7:0] cnt);
    cnt = 8'h00;
    repeat (n) begin
      tick(idx, 1);
      if (count_out[idx] === 1'b0) cnt = cnt + 8'h01;
    end
  endtask

  task automatic rise(input int idx);
    @(negedge ref_clk);
    gate[idx] = 1'b0;
    repeat (4) @(negedge ref_clk);
    gate[idx] = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic rd2(input logic [1:0] port, input logic [15:0] exp);
    i_host.rd(port, lo, oe);
    chk_bit("read oe", 1'b1, oe);
    i_host.rd(port, hi, oe);
    chk_byte("count lsb", exp[7:0], lo);
    chk_byte("count msb", exp[15:8], hi);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mode0();
    gate[0] = 1'b1;
    i_host.wr(timer_pkg::PORT_CTRL, 8'h30);
    tick(0, 1);
    chk_bit("mode0 out after set", 1'b0, count_out[0]);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h05);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h00);
    tick(0, 1);
    gate[0] = 1'b0;
    tick(0, 6);
    chk_bit("mode0 out gate low", 1'b0, count_out[0]);
    i_host.wr(timer_pkg::PORT_CTRL, 8'h00);
    rd2(timer_pkg::PORT_CNT0, 16'h0005);
    gate[0] = 1'b1;
    tick(0, 4);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h02);
    tick(0, 3);
    chk_bit("mode0 out halted", 1'b0, count_out[0]);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h00);
    tick(0, 2);
    chk_bit("mode0 out new count", 1'b0, count_out[0]);
    tick(0, 1);
    chk_bit("mode0 out terminal", 1'b1, count_out[0]);
  endtask

  task automatic t_latch();
    gate[1] = 1'b1;
    i_host.load16(timer_pkg::PORT_CNT1, 8'h70, 16'h1234);
    tick(1, 3);
    i_host.wr(timer_pkg::PORT_CTRL, 8'h4f);
    tick(1, 3);
    rd2(timer_pkg::PORT_CNT1, 16'h1232);
    gate[1] = 1'b0;
    tick(1, 2);
    rd2(timer_pkg::PORT_CNT1, 16'h122f);
    i_host.rd(timer_pkg::PORT_CTRL, lo, oe);
    chk_bit("control read oe", 1'b0, oe);
    chk_byte("control read data", 8'h12, lo);
    chk_bit("cnt1 out counting", 1'b0, count_out[1]);
    i_host.wr(timer_pkg::PORT_CTRL, 8'h50);
    i_host.wr(timer_pkg::PORT_CNT1, 8'h07);
    tick(1, 1);
    i_host.rd(timer_pkg::PORT_CNT1, lo, oe);
    chk_byte("lsb only read", 8'h07, lo);
    i_host.wr(timer_pkg::PORT_CTRL, 8'h60);
    i_host.wr(timer_pkg::PORT_CNT1, 8'h03);
    tick(1, 1);
    i_host.rd(timer_pkg::PORT_CNT1, lo, oe);
    chk_byte("msb only read", 8'h03, lo);
  endtask

  task automatic t_decimal();
    logic [7:0] cw [3] = '{8'hb1, 8'hb1, 8'hb0};
    logic [15:0] ld [3] = '{16'h1000, 16'h0000, 16'h0000};
    logic [15:0] ex [3] = '{16'h0999, 16'h9999, 16'hffff};
    gate[2] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      i_host.load16(timer_pkg::PORT_CNT2, cw[i], ld[i]);
      tick(2, 2);
      i_host.wr(timer_pkg::PORT_CTRL, 8'h80);
      rd2(timer_pkg::PORT_CNT2, ex[i]);
      chk_bit("cnt2 out counting", 1'b0, count_out[2]);
    end
  endtask

  task automatic t_rate();
    gate[0] = 1'b1;
    i_host.wr(timer_pkg::PORT_CTRL, 8'h3c);
    tick(0, 3);
    chk_bit("rate out before load", 1'b1, count_out[0]);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h03);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h00);
    tick(0, 2);
    lows(0, 9, c);
    chk_byte("rate lows", 8'h03, c);
    gate[0] = 1'b0;
    tick(0, 1);
    lows(0, 6, c);
    chk_byte("rate lows gate low", 8'h00, c);
    gate[0] = 1'b1;
    tick(0, 1);
    chk_bit("rate out gate rise", 1'b1, count_out[0]);
    tick(0, 2);
    chk_bit("rate restart low", 1'b0, count_out[0]);
  endtask

  task automatic t_square();
    // Square wave only runs with the gate high
    gate[0] = 1'b1;
    for (int n = 4; n < 6; n++) begin
      i_host.load16(timer_pkg::PORT_CNT0, (n == 4) ? 8'h36 : 8'h3e, 16'(n));
      tick(0, n + 2);
      lows(0, 2 * n, c);
      chk_byte("square lows", 8'(2 * (n / 2)), c);
    end
  endtask

  task automatic t_oneshot();
    gate[0] = 1'b0;
    i_host.load16(timer_pkg::PORT_CNT0, 8'h32, 16'h0003);
    tick(0, 2);
    rise(0);
    lows(0, 2, a);
    rd2(timer_pkg::PORT_CNT0, 16'h0002);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h06);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h00);
    lows(0, 4, c);
    chk_byte("oneshot pulse", 8'h03, a + c);
    rise(0);
    lows(0, 3, a);
    rise(0);
    lows(0, 10, c);
    chk_byte("oneshot retrigger", 8'h09, a + c);
  endtask

  task automatic t_strobe();
    gate[0] = 1'b1;
    i_host.wr(timer_pkg::PORT_CTRL, 8'h38);
    tick(0, 1);
    chk_bit("strobe out after set", 1'b1, count_out[0]);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h03);
    i_host.wr(timer_pkg::PORT_CNT0, 8'h00);
    tick(0, 2);
    gate[0] = 1'b0;
    tick(0, 3);
    gate[0] = 1'b1;
    tick(0, 1);
    chk_bit("strobe out suspended", 1'b1, count_out[0]);
    tick(0, 1);
    chk_bit("strobe out terminal", 1'b0, count_out[0]);
    tick(0, 1);
    chk_bit("strobe out after pulse", 1'b1, count_out[0]);
    gate[0] = 1'b0;
    i_host.load16(timer_pkg::PORT_CNT0, 8'h3a, 16'h0003);
    tick(0, 5);
    rise(0);
    lows(0, 8, c);
    chk_byte("hw strobe lows", 8'h01, c);
  endtask

  // ----------------------------------------------------------------
  // Run
  // ----------------------------------------------------------------
  task automatic conclude();
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    count_clk = 3'h0;
    gate = 3'h0;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    chk_bit("oe after reset", 1'b0, data_oe);
    chk_byte("out after reset", 8'h00, {5'h00, count_out});
    t_mode0();
    t_latch();
    t_decimal();
    t_rate();
    t_square();
    t_oneshot();
    t_strobe();
    conclude();
  end
endmodule
